// File: src/core_mode_and_irq_flag_bank.sv
// Notes on behaviour
// - With the stack-frame bit set, frame and stack pointers address 0x0000..0xffff flat, pages ignored.
// - With the stack-frame bit clear, those pointers address extended data space by paging when bit 15 is set, base space flat otherwise.
// - Rounding select at core control bit 1 picks biased rounding when 1, convergent when 0.
// - Multiplier mode at core control bit 0 picks integer multiply when 1, fractional when 0.
// - Priority level is the high priority bit above status word bits 7 to 5.
`timescale 1ns/1ps
`include "core_bank_defs.svh"

module core_mode_and_irq_flag_bank (
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   input  wire logic [15:0]              s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [15:0]              s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   input  wire logic [143:0]             irq_events,
   input  wire core_bank_pkg::word_type  cpu_status_word,
   input  wire core_bank_pkg::word_type  frame_pointer_reg,
   input  wire core_bank_pkg::word_type  stack_pointer_reg,
   input  wire logic [9:0]               data_read_page,
   input  wire logic [8:0]               data_write_page,
   output logic                          irq,
   output logic [47:0]                   irq_requests,
   output logic [3:0]                    cpu_priority_level,
   output logic                          rounding_biased,
   output logic                          multiply_integer,
   output logic                          stack_frame_active,
   output core_bank_pkg::eff_addr_type   frame_read_addr,
   output core_bank_pkg::eff_addr_type   frame_write_addr,
   output core_bank_pkg::eff_addr_type   stack_read_addr,
   output core_bank_pkg::eff_addr_type   stack_write_addr
);
   import core_bank_pkg::*;

   localparam int FLAG_WORDS = 9;
   localparam int EN_WORDS   = 3;
   localparam logic [13:0] FLAG_IDX [FLAG_WORDS] = '{
      `IRQ_FLAGS_0_IDX, `IRQ_FLAGS_1_IDX, `IRQ_FLAGS_2_IDX,
      `IRQ_FLAGS_3_IDX, `IRQ_FLAGS_4_IDX, `IRQ_FLAGS_5_IDX,
      `IRQ_FLAGS_6_IDX, `IRQ_FLAGS_8_IDX, `IRQ_FLAGS_9_IDX};
   localparam logic [13:0] EN_IDX [EN_WORDS] = '{
      `IRQ_ENABLES_0_IDX, `IRQ_ENABLES_1_IDX, `IRQ_ENABLES_2_IDX};

   localparam core_bank_state_type STATE_RESET = '{
      awready_ff:    1'b1,
      wready_ff:     1'b1,
      aw_held_ff:    1'b0,
      w_held_ff:     1'b0,
      aw_idx_ff:     14'h0000,
      wdata_ff:      16'h0000,
      wstrb_ff:      2'h0,
      bvalid_ff:     1'b0,
      bresp_ff:      `AXI_RESP_OKAY,
      arready_ff:    1'b1,
      rvalid_ff:     1'b0,
      rresp_ff:      `AXI_RESP_OKAY,
      rdata_ff:      16'h0000,
      core_ctl_ff:   `CORE_CONTROL_RESET,
      enables_ff:    {3{`IRQ_WORD_RESET}},
      requests_ff:   48'h000000000000,
      irq_ff:        1'b0,
      prio_level_ff: 4'h0,
      frame_rd_ff:   25'h0000000,
      frame_wr_ff:   25'h0000000,
      stack_rd_ff:   25'h0000000,
      stack_wr_ff:   25'h0000000};

   core_bank_state_type state_ff;
   core_bank_state_type nxt_state;

   word_type                flags       [FLAG_WORDS];
   logic [FLAG_WORDS-1:0]   flag_wr;
   logic                    write_fire;
   eff_addr_type            fp_rd;
   eff_addr_type            fp_wr;
   eff_addr_type            sp_rd;
   eff_addr_type            sp_wr;

   assign write_fire = state_ff.aw_held_ff && state_ff.w_held_ff && !state_ff.bvalid_ff;

   // ------------------------------------------------------------
   // flag words
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < FLAG_WORDS; gi++) begin : g_flags
         assign flag_wr[gi] = write_fire && (state_ff.aw_idx_ff == FLAG_IDX[gi]);
         irq_flag_word u_flag (
            .clk     (clk),
            .reset_n (reset_n),
            .wr_en   (flag_wr[gi]),
            .wr_data (state_ff.wdata_ff),
            .wr_strb (state_ff.wstrb_ff),
            .events  (irq_events[gi*16 +: 16]),
            .flags   (flags[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // pointer address mapping
   // ------------------------------------------------------------
   frame_addr_map u_frame_map (
      .stack_frame_active (state_ff.core_ctl_ff[`CC_FRAME_ACTIVE_BIT]),
      .pointer            (frame_pointer_reg),
      .data_read_page     (data_read_page),
      .data_write_page    (data_write_page),
      .rd_addr            (fp_rd),
      .wr_addr            (fp_wr)
   );

   frame_addr_map u_stack_map (
      .stack_frame_active (state_ff.core_ctl_ff[`CC_FRAME_ACTIVE_BIT]),
      .pointer            (stack_pointer_reg),
      .data_read_page     (data_read_page),
      .data_write_page    (data_write_page),
      .rd_addr            (sp_rd),
      .wr_addr            (sp_wr)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic [13:0] rd_idx;
      logic        rd_hit;
      word_type    rd_word;
      word_type    merged;
      logic        wr_hit;
      rd_idx  = s_axi_araddr[15:2];
      rd_hit  = 1'b0;
      rd_word = 16'h0000;
      merged  = 16'h0000;
      wr_hit  = 1'b0;
      nxt_state = state_ff;

      // write address and data, taken in either order
      if (s_axi_awvalid && state_ff.awready_ff) begin
         nxt_state.aw_held_ff = 1'b1;
         nxt_state.awready_ff = 1'b0;
         nxt_state.aw_idx_ff  = s_axi_awaddr[15:2];
      end
      if (s_axi_wvalid && state_ff.wready_ff) begin
         nxt_state.w_held_ff = 1'b1;
         nxt_state.wready_ff = 1'b0;
         nxt_state.wdata_ff  = s_axi_wdata[15:0];
         nxt_state.wstrb_ff  = s_axi_wstrb[1:0];
      end
      if (state_ff.bvalid_ff && s_axi_bready) begin
         nxt_state.bvalid_ff = 1'b0;
      end

      // commit a held write
      if (write_fire) begin
         for (int i = 0; i < FLAG_WORDS; i++) begin
            if (flag_wr[i]) begin
               wr_hit = 1'b1;
            end
         end
         for (int i = 0; i < EN_WORDS; i++) begin
            if (state_ff.aw_idx_ff == EN_IDX[i]) begin
               wr_hit = 1'b1;
               merged = state_ff.enables_ff[i];
               if (state_ff.wstrb_ff[0]) begin
                  merged[7:0] = state_ff.wdata_ff[7:0];
               end
               if (state_ff.wstrb_ff[1]) begin
                  merged[15:8] = state_ff.wdata_ff[15:8];
               end
               nxt_state.enables_ff[i] = merged;
            end
         end
         if (state_ff.aw_idx_ff == `CORE_CONTROL_IDX) begin
            wr_hit = 1'b1;
            if (state_ff.wstrb_ff[0]) begin
               nxt_state.core_ctl_ff = state_ff.wdata_ff[3:0];
            end
         end
         nxt_state.bvalid_ff  = 1'b1;
         nxt_state.bresp_ff   = wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
         nxt_state.aw_held_ff = 1'b0;
         nxt_state.w_held_ff  = 1'b0;
         nxt_state.awready_ff = 1'b1;
         nxt_state.wready_ff  = 1'b1;
      end

      // read decode
      if (rd_idx == `IRQ_FLAGS_0_IDX) begin
         rd_hit  = 1'b1;
         rd_word = flags[0];
      end else if (rd_idx == `IRQ_FLAGS_1_IDX) begin
         rd_hit  = 1'b1;
         rd_word = flags[1];
      end else if (rd_idx == `IRQ_FLAGS_2_IDX) begin
         rd_hit  = 1'b1;
         rd_word = flags[2];
      end else if (rd_idx == `IRQ_FLAGS_3_IDX) begin
         rd_hit  = 1'b1;
         rd_word = flags[3];
      end else if (rd_idx == `IRQ_FLAGS_4_IDX) begin
         rd_hit  = 1'b1;
         rd_word = flags[4];
      end else if (rd_idx == `IRQ_FLAGS_5_IDX) begin
         rd_hit  = 1'b1;
         rd_word = flags[5];
      end else if (rd_idx == `IRQ_FLAGS_6_IDX) begin
         rd_hit  = 1'b1;
         rd_word = flags[6];
      end else if (rd_idx == `IRQ_FLAGS_8_IDX) begin
         rd_hit  = 1'b1;
         rd_word = flags[7];
      end else if (rd_idx == `IRQ_FLAGS_9_IDX) begin
         rd_hit  = 1'b1;
         rd_word = flags[8];
      end else if (rd_idx == `IRQ_ENABLES_0_IDX) begin
         rd_hit  = 1'b1;
         rd_word = state_ff.enables_ff[0];
      end else if (rd_idx == `IRQ_ENABLES_1_IDX) begin
         rd_hit  = 1'b1;
         rd_word = state_ff.enables_ff[1];
      end else if (rd_idx == `IRQ_ENABLES_2_IDX) begin
         rd_hit  = 1'b1;
         rd_word = state_ff.enables_ff[2];
      end else if (rd_idx == `CORE_CONTROL_IDX) begin
         rd_hit  = 1'b1;
         rd_word = {12'h000, state_ff.core_ctl_ff} & `CC_IMPL_MASK;
      end else begin
         rd_hit  = 1'b0;
         rd_word = 16'h0000;
      end

      if (state_ff.rvalid_ff && s_axi_rready) begin
         nxt_state.rvalid_ff  = 1'b0;
         nxt_state.arready_ff = 1'b1;
      end
      if (s_axi_arvalid && state_ff.arready_ff) begin
         nxt_state.arready_ff = 1'b0;
         nxt_state.rvalid_ff  = 1'b1;
         nxt_state.rdata_ff   = rd_word;
         nxt_state.rresp_ff   = rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end

      // requests gated by enables, one level line
      for (int i = 0; i < EN_WORDS; i++) begin
         nxt_state.requests_ff[i] = flags[i] & state_ff.enables_ff[i];
      end
      nxt_state.irq_ff = |nxt_state.requests_ff;

      nxt_state.prio_level_ff = {state_ff.core_ctl_ff[`CC_PRIO_HIGH_BIT],
                                 cpu_status_word[`SR_PRIO_MSB:`SR_PRIO_LSB]};

      nxt_state.frame_rd_ff = fp_rd;
      nxt_state.frame_wr_ff = fp_wr;
      nxt_state.stack_rd_ff = sp_rd;
      nxt_state.stack_wr_ff = sp_wr;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= STATE_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign s_axi_awready      = state_ff.awready_ff;
   assign s_axi_wready       = state_ff.wready_ff;
   assign s_axi_bvalid       = state_ff.bvalid_ff;
   assign s_axi_bresp        = state_ff.bresp_ff;
   assign s_axi_arready      = state_ff.arready_ff;
   assign s_axi_rvalid       = state_ff.rvalid_ff;
   assign s_axi_rresp        = state_ff.rresp_ff;
   assign s_axi_rdata        = {16'h0000, state_ff.rdata_ff};
   assign irq                = state_ff.irq_ff;
   assign irq_requests       = state_ff.requests_ff;
   assign cpu_priority_level = state_ff.prio_level_ff;
   assign rounding_biased    = state_ff.core_ctl_ff[`CC_ROUNDING_BIT];
   assign multiply_integer   = state_ff.core_ctl_ff[`CC_MULT_INTEGER_BIT];
   assign stack_frame_active = state_ff.core_ctl_ff[`CC_FRAME_ACTIVE_BIT];
   assign frame_read_addr    = state_ff.frame_rd_ff;
   assign frame_write_addr   = state_ff.frame_wr_ff;
   assign stack_read_addr    = state_ff.stack_rd_ff;
   assign stack_write_addr   = state_ff.stack_wr_ff;

endmodule

// File: src/core_bank_defs.svh
`ifndef CORE_BANK_DEFS_SVH
`define CORE_BANK_DEFS_SVH

// ------------------------------------------------------------
// register indices (byte address = index * 4)
// ------------------------------------------------------------
`define IRQ_FLAGS_0_IDX     14'h0800
`define IRQ_FLAGS_1_IDX     14'h0802
`define IRQ_FLAGS_2_IDX     14'h0804
`define IRQ_FLAGS_3_IDX     14'h0806
`define IRQ_FLAGS_4_IDX     14'h0808
`define IRQ_FLAGS_5_IDX     14'h080a
`define IRQ_FLAGS_6_IDX     14'h080c
`define IRQ_FLAGS_8_IDX     14'h0810
`define IRQ_FLAGS_9_IDX     14'h0812
`define IRQ_ENABLES_0_IDX   14'h0820
`define IRQ_ENABLES_1_IDX   14'h0822
`define IRQ_ENABLES_2_IDX   14'h0824
`define CORE_CONTROL_IDX    14'h0880

// ------------------------------------------------------------
// core control fields
// ------------------------------------------------------------
`define CC_MULT_INTEGER_BIT 0
`define CC_ROUNDING_BIT     1
`define CC_FRAME_ACTIVE_BIT 2
`define CC_PRIO_HIGH_BIT    3
`define CC_IMPL_MASK        16'h000f

// ------------------------------------------------------------
// status word priority field
// ------------------------------------------------------------
`define SR_PRIO_MSB         7
`define SR_PRIO_LSB         5

// ------------------------------------------------------------
// reset values and bus answers
// ------------------------------------------------------------
`define IRQ_WORD_RESET      16'h0000
`define CORE_CONTROL_RESET  4'h0
`define AXI_RESP_OKAY       2'b00
`define AXI_RESP_SLVERR     2'b10

`endif

// File: src/core_bank_pkg.sv
package core_bank_pkg;

   typedef logic [15:0] word_type;
   typedef logic [24:0] eff_addr_type;

   typedef struct packed {
      word_type flags_ff;
   } flag_word_state_type;

   typedef struct packed {
      logic                awready_ff;
      logic                wready_ff;
      logic                aw_held_ff;
      logic                w_held_ff;
      logic [13:0]         aw_idx_ff;
      word_type            wdata_ff;
      logic [1:0]          wstrb_ff;
      logic                bvalid_ff;
      logic [1:0]          bresp_ff;
      logic                arready_ff;
      logic                rvalid_ff;
      logic [1:0]          rresp_ff;
      word_type            rdata_ff;
      logic [3:0]          core_ctl_ff;
      logic [2:0][15:0]    enables_ff;
      logic [2:0][15:0]    requests_ff;
      logic                irq_ff;
      logic [3:0]          prio_level_ff;
      eff_addr_type        frame_rd_ff;
      eff_addr_type        frame_wr_ff;
      eff_addr_type        stack_rd_ff;
      eff_addr_type        stack_wr_ff;
   } core_bank_state_type;

endpackage

// File: src/irq_flag_word.sv
`timescale 1ns/1ps
`include "core_bank_defs.svh"

module irq_flag_word (
   input  wire logic                clk,
   input  wire logic                reset_n,
   input  wire logic                wr_en,
   input  wire core_bank_pkg::word_type wr_data,
   input  wire logic [1:0]          wr_strb,
   input  wire core_bank_pkg::word_type events,
   output core_bank_pkg::word_type  flags
);
   import core_bank_pkg::*;

   flag_word_state_type state_ff;
   flag_word_state_type nxt_state;

   // ------------------------------------------------------------
   // byte-lane write, hardware set wins over software clear
   // ------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      if (wr_en) begin
         if (wr_strb[0]) begin
            nxt_state.flags_ff[7:0] = wr_data[7:0];
         end
         if (wr_strb[1]) begin
            nxt_state.flags_ff[15:8] = wr_data[15:8];
         end
      end
      nxt_state.flags_ff = nxt_state.flags_ff | events;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= '{flags_ff: `IRQ_WORD_RESET};
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign flags = state_ff.flags_ff;

endmodule

// File: src/frame_addr_map.sv
`timescale 1ns/1ps

module frame_addr_map (
   input  wire logic                     stack_frame_active,
   input  wire core_bank_pkg::word_type  pointer,
   input  wire logic [9:0]               data_read_page,
   input  wire logic [8:0]               data_write_page,
   output core_bank_pkg::eff_addr_type   rd_addr,
   output core_bank_pkg::eff_addr_type   wr_addr
);
   import core_bank_pkg::*;

   // ------------------------------------------------------------
   // flat 16-bit range when the frame is active or pointer bit 15 is clear, else paged
   // ------------------------------------------------------------
   always_comb begin
      if (stack_frame_active || !pointer[15]) begin
         rd_addr = {9'h000, pointer};
         wr_addr = {9'h000, pointer};
      end else begin
         rd_addr = {data_read_page, pointer[14:0]};
         wr_addr = {1'b0, data_write_page, pointer[14:0]};
      end
   end

endmodule

// File: verification/core_bank_chk.sv
`timescale 1ns/1ps

module core_bank_chk (
   input wire logic                         clk,
   input wire logic                         reset_n,
   input wire logic                         s_axi_awvalid,
   input wire logic                         s_axi_awready,
   input wire logic                         s_axi_wvalid,
   input wire logic                         s_axi_wready,
   input wire logic [1:0]                   s_axi_bresp,
   input wire logic                         s_axi_bvalid,
   input wire logic                         s_axi_bready,
   input wire logic                         s_axi_arvalid,
   input wire logic                         s_axi_arready,
   input wire logic [31:0]                  s_axi_rdata,
   input wire logic                         s_axi_rvalid,
   input wire logic                         irq,
   input wire logic [47:0]                  irq_requests,
   input wire core_bank_pkg::word_type      cpu_status_word,
   input wire core_bank_pkg::word_type      frame_pointer_reg,
   input wire core_bank_pkg::word_type      stack_pointer_reg,
   input wire logic [9:0]                   data_read_page,
   input wire logic [8:0]                   data_write_page,
   input wire logic [3:0]                   cpu_priority_level,
   input wire logic                         stack_frame_active,
   input wire core_bank_pkg::eff_addr_type  frame_read_addr,
   input wire core_bank_pkg::eff_addr_type  stack_write_addr
);
   import core_bank_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ------------------------------------------------------------
   // bus handshakes
   // ------------------------------------------------------------
   sequence both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   a_write_answer: assert property (both_taken |-> ##[1:4] s_axi_bvalid)
      else $error("write response missing");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:4] s_axi_rvalid)
      else $error("read response missing");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   // ------------------------------------------------------------
   // core modes and requests
   // ------------------------------------------------------------
   a_prio_join: assert property ($past(reset_n) |-> cpu_priority_level[2:0] == $past(cpu_status_word[7:5]))
      else $error("priority low field wrong");
   a_flat_frame: assert property ($past(reset_n) && $past(stack_frame_active)
      |-> frame_read_addr == {9'h000, $past(frame_pointer_reg)})
      else $error("flat frame address wrong");
   a_paged_read: assert property ($past(reset_n) && !$past(stack_frame_active) && $past(frame_pointer_reg[15])
      |-> frame_read_addr == {$past(data_read_page), $past(frame_pointer_reg[14:0])})
      else $error("paged read address wrong");
   a_paged_write: assert property ($past(reset_n) && !$past(stack_frame_active) && $past(stack_pointer_reg[15])
      |-> stack_write_addr == {1'b0, $past(data_write_page), $past(stack_pointer_reg[14:0])})
      else $error("paged write address wrong");
   a_irq_quiet: assert property ((irq_requests == 48'h0) [*2] |-> !irq)
      else $error("irq without request");
endmodule

// File: verification/test_core_mode_and_irq_flag_bank.sv
`timescale 1ns/1ps
`include "core_bank_defs.svh"

module test_core_mode_and_irq_flag_bank;
   import core_bank_pkg::*;
   logic         clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
   logic         rounding_biased, multiply_integer, stack_frame_active;
   logic [15:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0]  s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0]   s_axi_wstrb, cpu_priority_level;
   logic [1:0]   s_axi_bresp, s_axi_rresp, resp;
   logic [143:0] irq_events;
   logic [47:0]  irq_requests;
   word_type     cpu_status_word, frame_pointer_reg, stack_pointer_reg;
   logic [9:0]   data_read_page;
   logic [8:0]   data_write_page;
   eff_addr_type frame_read_addr, frame_write_addr, stack_read_addr, stack_write_addr;
   int           fail_count, tests_run, cycles;
   localparam logic [15:0] reg_addr [0:11] = '{16'h2000, 16'h2008, 16'h2010, 16'h2018, 16'h2020, 16'h2028,
      16'h2030, 16'h2040, 16'h2048, 16'h2080, 16'h2088, 16'h2090};

   core_mode_and_irq_flag_bank dut_u (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .irq_events, .cpu_status_word, .frame_pointer_reg, .stack_pointer_reg, .data_read_page, .data_write_page,
      .irq, .irq_requests, .cpu_priority_level, .rounding_biased, .multiply_integer, .stack_frame_active,
      .frame_read_addr, .frame_write_addr, .stack_read_addr, .stack_write_addr);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   // ------------------------------------------------------------
   // bus tasks
   // ------------------------------------------------------------
   task automatic check(input logic [48:0] seen, input logic [48:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic axi_write(input logic [15:0] a, input word_type d, input logic [3:0] s, output logic [1:0] r);
      int n;
      @(posedge clk);
      n = 0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {16'h0000, d};
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 50) fail_count++;
   endtask

   task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 50) fail_count++;
   endtask

   task automatic wr_ok(input logic [15:0] a, input word_type d);
      logic [1:0] r;
      axi_write(a, d, 4'h3, r);
      check(r, `AXI_RESP_OKAY);
   endtask

   task automatic rd_check(input logic [15:0] a, input word_type exp);
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(a, d, r);
      check(r, `AXI_RESP_OKAY);
      check(d, {16'h0000, exp});
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 68'h0;
      {fail_count, tests_run, cycles} = 0;
      irq_events = '0;
      cpu_status_word = 16'h00a0;
      frame_pointer_reg = 16'h9abc;
      stack_pointer_reg = 16'hc234;
      data_read_page = 10'h2a5;
      data_write_page = 9'h13c;
      reset_n = 1'b0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      foreach (reg_addr[i]) begin
         rd_check(reg_addr[i], 16'h0000);
         wr_ok(reg_addr[i], 16'ha5c3);
         rd_check(reg_addr[i], 16'ha5c3);
         wr_ok(reg_addr[i], 16'h0000);
      end
      axi_write(reg_addr[11], 16'hffff, 4'h1, resp);
      check(resp, `AXI_RESP_OKAY);
      rd_check(reg_addr[11], 16'h00ff);
      wr_ok(reg_addr[11], 16'h0000);
      axi_write(16'h3000, 16'h1234, 4'h3, resp);
      check(resp, `AXI_RESP_SLVERR);
      axi_read(16'h3000, rdat, resp);
      check(resp, `AXI_RESP_SLVERR);
      check(rdat, 32'h00000000);
      for (int v = 0; v < 16; v++) begin
         wr_ok(16'h2200, {12'hfff, v[3:0]});
         rd_check(16'h2200, {12'h000, v[3:0]});
         check(multiply_integer, v[0]);
         check(rounding_biased, v[1]);
         check(stack_frame_active, v[2]);
         check(cpu_priority_level, {v[3], 3'b101});
         check(frame_read_addr, v[2] ? {9'h000, 16'h9abc} : {10'h2a5, 15'h1abc});
         check(frame_write_addr, v[2] ? {9'h000, 16'h9abc} : {1'b0, 9'h13c, 15'h1abc});
         check(stack_read_addr, v[2] ? {9'h000, 16'hc234} : {10'h2a5, 15'h4234});
         check(stack_write_addr, v[2] ? {9'h000, 16'hc234} : {1'b0, 9'h13c, 15'h4234});
      end
      cpu_status_word <= 16'hff5f;
      repeat (3) @(posedge clk);
      check(cpu_priority_level, 4'ha);
      for (int w = 0; w < 3; w++) begin
         wr_ok(reg_addr[9+w], 16'h0008);
         irq_events[16*w+3] <= 1'b1;
         irq_events[16*w+4] <= 1'b1;
         @(posedge clk);
         irq_events <= '0;
         repeat (3) @(posedge clk);
         check(irq_requests, 48'h8 << (16*w));
         check(irq, 1'b1);
         rd_check(reg_addr[w], 16'h0018);
         wr_ok(reg_addr[9+w], 16'h0000);
         repeat (2) @(posedge clk);
         check({irq, irq_requests}, 49'h0);
         wr_ok(reg_addr[9+w], 16'h0008);
         repeat (2) @(posedge clk);
         check(irq_requests, 48'h8 << (16*w));
         wr_ok(reg_addr[w], 16'h0000);
         repeat (2) @(posedge clk);
         check({irq, irq_requests}, 49'h0);
         wr_ok(reg_addr[9+w], 16'h0000);
      end
      irq_events[51] <= 1'b1;
      @(posedge clk);
      irq_events <= '0;
      repeat (3) @(posedge clk);
      check(irq, 1'b0);
      rd_check(reg_addr[3], 16'h0008);
      wrap_up();
   end
endmodule

bind core_mode_and_irq_flag_bank core_bank_chk chk_u (.clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .irq, .irq_requests, .cpu_status_word, .frame_pointer_reg, .stack_pointer_reg,
   .data_read_page, .data_write_page, .cpu_priority_level, .stack_frame_active, .frame_read_addr,
   .stack_write_addr);
